// ---- omd_pkg.sv ----
// How it works
// - Phase magnitudes compared against unsigned limits
// - Overvoltage sets status and phase flags
// - Enabled overvoltage pulls interrupt line low
// - Overvoltage write-one clears flag, phases, line
// - Overcurrent sets flags, enabled pulls line
// - Overcurrent write-one clears flag, phases, line
// - Full-scale limit never detects
// - Zero limit detects continuously
// - Voltage and current limits read back with top byte zero
// - Three phase currents summed, 28-bit signed
// - Sum each sample period, done flag
// - Sum versus neutral mismatch sets flag
// - Enabled mismatch pulls line, write-one clears
// - Mismatch limit resets zero, nonpositive fires
// - Mismatch limit uses current sample scale
// - Sum reads with top nibble zero
// - Mismatch limit sign-extended to 28 bits
package omd_pkg;

	// ==========================================================
	// Widths
	localparam int unsigned DW   = 24;
	localparam int unsigned SUMW = 28;
	localparam int unsigned BUSW = 32;
	localparam int unsigned NPH  = 3;

	// ==========================================================
	// Scale and reset values
	localparam logic [DW-1:0] FULL_SCALE     = 24'h5a7540;
	localparam logic [DW-1:0] OV_THR_RST     = FULL_SCALE;
	localparam logic [DW-1:0] OI_THR_RST     = FULL_SCALE;
	localparam logic [DW-1:0] MM_THR_RST     = 24'h000000;
	localparam logic [DW-1:0] LIMIT_ZERO     = 24'h000000;

	// ==========================================================
	// Field positions
	localparam int unsigned STS0_DONE_BIT = 17;
	localparam int unsigned STS1_OI_BIT   = 17;
	localparam int unsigned STS1_OV_BIT   = 18;
	localparam int unsigned STS1_MM_BIT   = 20;
	localparam int unsigned PH_OI_LSB     = 3;
	localparam int unsigned PH_OV_LSB     = 9;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_HZ;
	localparam int unsigned SAMPLE_PERIOD_NS = 125_000;
	localparam int unsigned SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;

	// ==========================================================
	// Register selection on the register port
	typedef enum logic [2:0] {
		SEL_OV_THR,
		SEL_OI_THR,
		SEL_SUM,
		SEL_MM_THR,
		SEL_EVENT_STATUS_WORD_0,
		SEL_EVENT_STATUS_WORD_1,
		SEL_ENABLE1,
		SEL_PHASE
	} omd_sel_t;

	// Register access request
	typedef struct packed {
		logic            wr;
		logic            rd;
		omd_sel_t        sel;
		logic [BUSW-1:0] data;
	} omd_req_t;

	// Instantaneous samples from the datapath
	typedef struct packed {
		logic [NPH-1:0][DW-1:0] voltage_sample;
		logic [NPH-1:0][DW-1:0] phase_current_sample;
		logic [DW-1:0]          neutral_current_sample;
	} omd_samples_t;

endpackage : omd_pkg

// ---- omd_mag.sv ----
// ==========================================================
// Magnitude of a two's complement value
module omd_mag #(
	parameter int unsigned W = 24
) (
	input  wire logic [W-1:0] value,
	output logic      [W-1:0] magnitude
);
	import omd_pkg::*;

	// Width check
	if (W < 2) begin : g_bad_w
		$error("omd_mag width too small");
	end

	// Negate negative values; most negative fits unsigned
	always_comb begin
		magnitude = value[W-1] ? (~value + 1'b1) : value;
	end

endmodule : omd_mag

// ---- omd_tick_div.sv ----
// ==========================================================
// Divider giving a one-cycle enable every PERIOD clocks
module omd_tick_div #(
	parameter int unsigned PERIOD = 1250
) (
	input  wire logic clock,
	input  wire logic rst,
	output logic      tick
);
	import omd_pkg::*;

	localparam int unsigned CW = $clog2(PERIOD);

	typedef struct packed {
		logic [CW-1:0] count;
		logic          tick;
	} omd_div_state_t;

	omd_div_state_t s_q;
	omd_div_state_t s_d;

	if (PERIOD < 2) begin : g_bad_period
		$error("omd_tick_div period too small");
	end

	// Count down, pulse on wrap
	always_comb begin
		s_d      = s_q;
		s_d.tick = 1'b0;
		if (s_q.count == '0) begin
			s_d.count = CW'(PERIOD - 1);
			s_d.tick  = 1'b1;
		end else begin
			s_d.count = s_q.count - 1'b1;
		end
	end

	// State register
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign tick = s_q.tick;

endmodule : omd_tick_div

// ---- omd_detector.sv ----
// ==========================================================
// Overlimit and neutral mismatch event detector
module omd_detector #(
	parameter int unsigned TICK_CYCLES = omd_pkg::SAMPLE_CYCLES
) (
	input  wire logic                 clock,
	input  wire logic                 rst,
	input  wire omd_pkg::omd_samples_t samples,
	input  wire omd_pkg::omd_req_t     req,
	output logic [omd_pkg::BUSW-1:0]  rd_data,
	output logic                      event_interrupt_line_1_n
);
	import omd_pkg::*;

	// ==========================================================
	// Elaboration checks
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("omd_detector tick period too small");
	end

	// Sum of three samples needs two bits of headroom
	if (SUMW < DW + 2) begin : g_bad_sumw
		$error("omd_detector sum width too small");
	end

	// Widest register image must fit the port word
	if (BUSW < SUMW) begin : g_bad_busw
		$error("omd_detector port word too narrow");
	end

	// Flag and phase fields must sit inside the port word, apart
	if (STS1_MM_BIT >= BUSW || PH_OV_LSB + NPH > BUSW || PH_OI_LSB + NPH > PH_OV_LSB) begin : g_bad_field
		$error("omd_detector field outside port word");
	end

	// ==========================================================
	// State
	typedef struct packed {
		logic [DW-1:0]   ov_thr;
		logic [DW-1:0]   oi_thr;
		logic [DW-1:0]   mm_thr;
		logic [SUMW-1:0] phase_current_sum;
		logic            computation_done;
		logic            overvoltage_flag;
		logic            overcurrent_flag;
		logic            neutral_mismatch_flag;
		logic [NPH-1:0]  overvoltage_phase_bits;
		logic [NPH-1:0]  overcurrent_phase_bits;
		logic            en_ov;
		logic            en_oi;
		logic            en_mm;
		logic            irq_n;
		logic [BUSW-1:0] rd_data;
	} omd_state_t;

	omd_state_t s_q;
	omd_state_t s_d;

	// ==========================================================
	// Sample period enable
	logic sample_tick;

	omd_tick_div #(
		.PERIOD (TICK_CYCLES)
	) u_tick (
		.clock (clock),
		.rst   (rst),
		.tick  (sample_tick)
	);

	// ==========================================================
	// Magnitudes of every phase sample
	logic [NPH-1:0][DW-1:0] volt_mag;
	logic [NPH-1:0][DW-1:0] cur_mag;

	for (genvar p = 0; p < NPH; p++) begin : g_phase
		omd_mag #(
			.W (DW)
		) u_vmag (
			.value     (samples.voltage_sample[p]),
			.magnitude (volt_mag[p])
		);
		omd_mag #(
			.W (DW)
		) u_imag (
			.value     (samples.phase_current_sample[p]),
			.magnitude (cur_mag[p])
		);
	end

	// ==========================================================
	// Per-phase limit comparison
	logic [NPH-1:0] ov_hit;
	logic [NPH-1:0] oi_hit;
	logic           ov_armed;
	logic           oi_armed;

	// Limit at or above full scale disarms the check, so an
	// out-of-range sample code cannot fire it either
	always_comb begin
		ov_armed = (s_q.ov_thr < FULL_SCALE);
		oi_armed = (s_q.oi_thr < FULL_SCALE);
	end

	// Strictly above limit; zero limit always fires
	always_comb begin
		for (int p = 0; p < NPH; p++) begin
			ov_hit[p] = ov_armed && ((s_q.ov_thr == LIMIT_ZERO)
			          || (volt_mag[p] > s_q.ov_thr));
			oi_hit[p] = oi_armed && ((s_q.oi_thr == LIMIT_ZERO)
			          || (cur_mag[p] > s_q.oi_thr));
		end
	end

	// ==========================================================
	// Sum of the phase currents
	logic [SUMW-1:0] sum_now;

	// Sign-extend each sample and add
	always_comb begin
		sum_now = '0;
		for (int p = 0; p < NPH; p++) begin
			sum_now = sum_now + {{(SUMW-DW){samples.phase_current_sample[p][DW-1]}},
			                     samples.phase_current_sample[p]};
		end
	end

	// ==========================================================
	// Mismatch against neutral current
	logic [SUMW-1:0] sum_mag;
	logic [DW-1:0]   neutral_mag;
	logic [SUMW-1:0] neutral_wide;
	logic [SUMW-1:0] mm_diff;
	logic [SUMW-1:0] mm_thr_wide;
	logic            mm_hit;

	omd_mag #(
		.W (SUMW)
	) u_sum_mag (
		.value     (sum_now),
		.magnitude (sum_mag)
	);

	omd_mag #(
		.W (DW)
	) u_neutral_mag (
		.value     (samples.neutral_current_sample),
		.magnitude (neutral_mag)
	);

	// Sum of three samples stays below the sign bit of the wide
	// word, so its magnitude never wraps
	// Absolute difference, limit in current scale
	always_comb begin
		neutral_wide = {{(SUMW-DW){1'b0}}, neutral_mag};
		mm_diff      = (sum_mag >= neutral_wide) ? (sum_mag - neutral_wide)
		                                         : (neutral_wide - sum_mag);
		mm_thr_wide  = {{(SUMW-DW){s_q.mm_thr[DW-1]}}, s_q.mm_thr};
		// Zero or negative limit fires every period
		mm_hit       = mm_thr_wide[SUMW-1] || (s_q.mm_thr == LIMIT_ZERO)
		            || (mm_diff > mm_thr_wide);
	end

	// ==========================================================
	// Host write decode
	logic wr_event_status_word_0;
	logic wr_event_status_word_1;
	logic clr_done;
	logic clr_ov;
	logic clr_oi;
	logic clr_mm;

	// Write-one-to-clear strobes
	// Bits written as zero leave their flags alone
	always_comb begin
		wr_event_status_word_0 = req.wr && (req.sel == SEL_EVENT_STATUS_WORD_0);
		wr_event_status_word_1 = req.wr && (req.sel == SEL_EVENT_STATUS_WORD_1);
		clr_done   = wr_event_status_word_0 && req.data[STS0_DONE_BIT];
		clr_ov     = wr_event_status_word_1 && req.data[STS1_OV_BIT];
		clr_oi     = wr_event_status_word_1 && req.data[STS1_OI_BIT];
		clr_mm     = wr_event_status_word_1 && req.data[STS1_MM_BIT];
	end

	// ==========================================================
	// Detection sets, gated by the sample period
	logic [NPH-1:0] set_ov_ph;
	logic [NPH-1:0] set_oi_ph;
	logic           set_mm;

	// Samples only count on the tick; between ticks they may be stale
	always_comb begin
		set_ov_ph = sample_tick ? ov_hit : '0;
		set_oi_ph = sample_tick ? oi_hit : '0;
		set_mm    = sample_tick && mm_hit;
	end

	// ==========================================================
	// Read image of each register
	logic [BUSW-1:0] event_status_word_0_word;
	logic [BUSW-1:0] event_status_word_1_word;
	logic [BUSW-1:0] enable1_word;
	logic [BUSW-1:0] phase_word;
	logic [BUSW-1:0] read_value;

	always_comb begin
		event_status_word_0_word                   = '0;
		event_status_word_0_word[STS0_DONE_BIT]    = s_q.computation_done;
		event_status_word_1_word                   = '0;
		event_status_word_1_word[STS1_OV_BIT]      = s_q.overvoltage_flag;
		event_status_word_1_word[STS1_OI_BIT]      = s_q.overcurrent_flag;
		event_status_word_1_word[STS1_MM_BIT]      = s_q.neutral_mismatch_flag;
		enable1_word                   = '0;
		enable1_word[STS1_OV_BIT]      = s_q.en_ov;
		enable1_word[STS1_OI_BIT]      = s_q.en_oi;
		enable1_word[STS1_MM_BIT]      = s_q.en_mm;
		phase_word                     = '0;
		phase_word[PH_OV_LSB +: NPH]   = s_q.overvoltage_phase_bits;
		phase_word[PH_OI_LSB +: NPH]   = s_q.overcurrent_phase_bits;
	end

	// Select the word for a read
	always_comb begin
		case (req.sel)
			SEL_OV_THR: begin
				read_value = {{(BUSW-DW){1'b0}}, s_q.ov_thr};
			end
			SEL_OI_THR: begin
				read_value = {{(BUSW-DW){1'b0}}, s_q.oi_thr};
			end
			SEL_SUM: begin
				read_value = {{(BUSW-SUMW){1'b0}}, s_q.phase_current_sum};
			end
			SEL_MM_THR: begin
				read_value = {{(BUSW-SUMW){1'b0}}, mm_thr_wide};
			end
			SEL_EVENT_STATUS_WORD_0: begin
				read_value = event_status_word_0_word;
			end
			SEL_EVENT_STATUS_WORD_1: begin
				read_value = event_status_word_1_word;
			end
			SEL_ENABLE1: begin
				read_value = enable1_word;
			end
			SEL_PHASE: begin
				read_value = phase_word;
			end
			default: begin
				read_value = '0;
			end
		endcase
	end

	// ==========================================================
	// Next state
	always_comb begin
		s_d = s_q;

		// New sum every sample period, done flag marks it
		if (sample_tick) begin
			s_d.phase_current_sum = sum_now;
		end
		// Done: set wins over host clear
		s_d.computation_done = (s_q.computation_done && !clr_done)
		                     || sample_tick;

		// Clear whole event group, then apply new sets
		if (clr_ov) begin
			s_d.overvoltage_flag       = 1'b0;
			s_d.overvoltage_phase_bits = '0;
		end
		if (clr_oi) begin
			s_d.overcurrent_flag       = 1'b0;
			s_d.overcurrent_phase_bits = '0;
		end
		if (clr_mm) begin
			s_d.neutral_mismatch_flag = 1'b0;
		end

		// Sticky sets; repeated hits keep flags set
		s_d.overvoltage_phase_bits = s_d.overvoltage_phase_bits | set_ov_ph;
		s_d.overcurrent_phase_bits = s_d.overcurrent_phase_bits | set_oi_ph;
		if (|set_ov_ph) begin
			s_d.overvoltage_flag = 1'b1;
		end
		if (|set_oi_ph) begin
			s_d.overcurrent_flag = 1'b1;
		end
		if (set_mm) begin
			s_d.neutral_mismatch_flag = 1'b1;
		end

		// Register writes; upper bits above the field ignored
		if (req.wr) begin
			case (req.sel)
				SEL_OV_THR: begin
					s_d.ov_thr = req.data[DW-1:0];
				end
				SEL_OI_THR: begin
					s_d.oi_thr = req.data[DW-1:0];
				end
				SEL_MM_THR: begin
					s_d.mm_thr = req.data[DW-1:0];
				end
				SEL_ENABLE1: begin
					s_d.en_ov = req.data[STS1_OV_BIT];
					s_d.en_oi = req.data[STS1_OI_BIT];
					s_d.en_mm = req.data[STS1_MM_BIT];
				end
				default: begin
				end
			endcase
		end

		// Line low in the same cycle an enabled flag sets
		// Taken from the next flags and enables, so a clear and its
		// release land on one edge with no extra cycle of delay
		s_d.irq_n = !((s_d.overvoltage_flag && s_d.en_ov)
		           || (s_d.overcurrent_flag && s_d.en_oi)
		           || (s_d.neutral_mismatch_flag && s_d.en_mm));

		// Read data held until the next read
		// Image is the state before this edge; a same-edge write
		// only shows on the following read
		if (req.rd) begin
			s_d.rd_data = read_value;
		end
	end

	// ==========================================================
	// State register
	// Overlimit checks leave reset disarmed; the zero mismatch limit
	// fires until the host programs a positive one
	always_ff @(posedge clock) begin
		if (rst) begin
			s_q        <= '0;
			s_q.ov_thr <= OV_THR_RST;
			s_q.oi_thr <= OI_THR_RST;
			s_q.mm_thr <= MM_THR_RST;
			s_q.irq_n  <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================================
	// Outputs
	assign rd_data                  = s_q.rd_data;
	assign event_interrupt_line_1_n = s_q.irq_n;

endmodule : omd_detector

// ---- omd_detector_sva.sv ----
// ==========================================================
// Port checker for the event detector
module omd_detector_sva #(
	parameter int unsigned TICK_CYCLES = 8
) (
	input wire logic                     clock,
	input wire logic                     rst,
	input wire omd_pkg::omd_samples_t    samples,
	input wire omd_pkg::omd_req_t        req,
	input wire logic [omd_pkg::BUSW-1:0] rd_data,
	input wire logic                     event_interrupt_line_1_n
);
	timeunit 1ns;
	timeprecision 1ns;
	import omd_pkg::*;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	// Reset leaves read data clear and line released
	reset_state_a: assert property (disable iff (1'b0) rst |=>
		rd_data == '0 && event_interrupt_line_1_n) else $error("reset state wrong");
	// Read padding of limits, sum and mismatch limit
	limit_pad_a: assert property (req.rd && req.sel inside {SEL_OV_THR, SEL_OI_THR} |=>
		rd_data[31:24] == 8'h00) else $error("limit top byte not zero");
	sum_pad_a: assert property (req.rd && req.sel == SEL_SUM |=>
		rd_data[31:28] == 4'h0) else $error("sum top nibble not zero");
	mm_ext_a: assert property (req.rd && req.sel == SEL_MM_THR |=>
		rd_data[31:28] == 4'h0 && rd_data[27:24] == {4{rd_data[23]}}) else $error("mm limit extension");
	// Back-to-back write then read returns the written limit
	limit_echo_a: assert property (req.wr && !req.rd && req.sel == SEL_OV_THR ##1
		req.rd && !req.wr && req.sel == SEL_OV_THR |=> rd_data == {8'h00, $past(req.data[23:0], 2)})
		else $error("ov limit readback");
	mm_echo_a: assert property (req.wr && !req.rd && req.sel == SEL_MM_THR ##1
		req.rd && !req.wr && req.sel == SEL_MM_THR |=>
		rd_data == {4'h0, {4{$past(req.data[23], 2)}}, $past(req.data[23:0], 2)})
		else $error("mm limit readback");
	// Line follows enabled flags
	irq_release_a: assert property (req.wr && req.sel == SEL_ENABLE1 && req.data[20] == 1'b0 &&
		req.data[18:17] == 2'b00 |=> event_interrupt_line_1_n) else $error("line low with no enable");
	irq_cause_a: assert property (!event_interrupt_line_1_n && req.rd && !req.wr &&
		req.sel == SEL_EVENT_STATUS_WORD_1 |=> |{rd_data[20], rd_data[18:17]}) else $error("line low with no flag");
endmodule : omd_detector_sva

bind omd_detector omd_detector_sva #(.TICK_CYCLES(TICK_CYCLES)) sva (.clock(clock), .rst(rst),
	.samples(samples), .req(req), .rd_data(rd_data),
	.event_interrupt_line_1_n(event_interrupt_line_1_n));

// ---- omd_host.sv ----
// ==========================================================
// Host side of the register port
module omd_host (
	input  wire logic                     clock,
	input  wire logic [omd_pkg::BUSW-1:0] rd_data,
	output omd_pkg::omd_req_t             req
);
	timeunit 1ns;
	timeprecision 1ns;
	import omd_pkg::*;

	initial req = '0;

	// One access; a write is followed at once by a read-back
	task automatic xfer(input omd_sel_t s, input logic w, input logic [BUSW-1:0] d,
		output logic [BUSW-1:0] q);
		@(posedge clock);
		req <= '{wr: w, rd: !w, sel: s, data: d};
		if (w) begin
			@(posedge clock);
			req <= '{wr: 1'b0, rd: 1'b1, sel: s, data: d};
		end
		@(posedge clock);
		req <= '{wr: 1'b0, rd: 1'b0, sel: s, data: d};
		@(negedge clock);
		q = rd_data;
	endtask : xfer

	// Event service: status, then phases, then write-one clear
	task automatic service(input int unsigned b, output logic [BUSW-1:0] st,
		output logic [BUSW-1:0] ph);
		logic [BUSW-1:0] q;
		xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, st);
		xfer(SEL_PHASE, 1'b0, '0, ph);
		xfer(SEL_EVENT_STATUS_WORD_1, 1'b1, 32'h00000001 << b, q);
	endtask : service
endmodule : omd_host

// ---- omd_detector_tb_top.sv ----
// ==========================================================
// Testbench for the event detector
module omd_detector_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import omd_pkg::*;

	localparam int unsigned TICKS = 8;
	logic            clock = 1'b0;
	logic            rst = 1'b1;
	omd_samples_t    samples = '0;
	omd_samples_t    s;
	omd_req_t        req;
	logic [BUSW-1:0] rd_data;
	logic [BUSW-1:0] q;
	logic [BUSW-1:0] st;
	logic [BUSW-1:0] ph;
	logic            event_interrupt_line_1_n;
	int unsigned     b;
	int unsigned     lsb;
	int              error_cnt = 0;
	int              tests_run = 0;

	always #50 clock = ~clock;

	omd_detector #(.TICK_CYCLES(TICKS)) dut (.clock(clock), .rst(rst), .samples(samples),
		.req(req), .rd_data(rd_data), .event_interrupt_line_1_n(event_interrupt_line_1_n));
	omd_host host (.clock(clock), .rd_data(rd_data), .req(req));

	// Compare and count
	task automatic check(input string what, input logic [BUSW-1:0] seen,
		input logic [BUSW-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic final_report();
		$display("Checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : final_report

	// Hold samples across at least one sample tick
	task automatic drive(input omd_samples_t t);
		@(posedge clock);
		samples <= t;
		repeat (TICKS + 2) @(posedge clock);
		@(negedge clock);
	endtask : drive

	// One phase of voltage (k=0) or current (k=1) set to v
	task automatic poke(input int unsigned k, input int p, input logic [23:0] v);
		omd_samples_t t;
		t = '0;
		t.voltage_sample[p] = k ? 24'h000000 : v;
		t.phase_current_sample[p] = k ? v : 24'h000000;
		drive(t);
	endtask : poke

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		// Reset values; zero and negative mismatch limits always fire
		host.xfer(SEL_OI_THR, 1'b0, '0, q);
		check("oi limit", q, {8'h00, FULL_SCALE});
		host.xfer(SEL_MM_THR, 1'b0, '0, q);
		check("mm limit", q, 32'h00000000);
		drive('0);
		check("line idle", {31'h0, event_interrupt_line_1_n}, 32'h1);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, q);
		check("mm zero", q & 32'h00100000, 32'h00100000);
		host.xfer(SEL_MM_THR, 1'b1, 32'h00800000, q);
		check("mm neg", q, 32'h0f800000);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b1, 32'h00100000, q);
		drive('0);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, q);
		check("mm neg fires", q & 32'h00100000, 32'h00100000);
		// Positive limit; an equal difference does not fire
		host.xfer(SEL_MM_THR, 1'b1, 32'h00000100, q);
		check("mm pos", q, 32'h00000100);
		s = '0;
		s.phase_current_sample[0] = 24'h000200;
		s.neutral_current_sample = 24'hffff00;
		drive(s);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b1, 32'h00100000, q);
		drive(s);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, q);
		check("mm equal", q & 32'h00100000, 32'h0);
		host.xfer(SEL_SUM, 1'b0, '0, q);
		check("sum", q, 32'h00000200);
		host.xfer(SEL_EVENT_STATUS_WORD_0, 1'b0, '0, q);
		check("done", q & 32'h00020000, 32'h00020000);
		// Enabled mismatch pulls the line; write-one releases it
		host.xfer(SEL_ENABLE1, 1'b1, 32'h00100000, q);
		s.neutral_current_sample = 24'h0000ff;
		drive(s);
		check("mm line", {31'h0, event_interrupt_line_1_n}, 32'h0);
		s.neutral_current_sample = 24'hffff00;
		drive(s);
		host.service(STS1_MM_BIT, st, ph);
		check("mm flag", st & 32'h00100000, 32'h00100000);
		check("mm release", {31'h0, event_interrupt_line_1_n}, 32'h1);
		// Sum of extreme currents
		s = '0;
		s.phase_current_sample = {3{24'h800000}};
		drive(s);
		host.xfer(SEL_SUM, 1'b0, '0, q);
		check("sum min", q, 32'h0e800000);
		s.phase_current_sample = {3{24'h7fffff}};
		drive(s);
		host.xfer(SEL_SUM, 1'b0, '0, q);
		check("sum max", q, 32'h017ffffd);
		// Over-limit per kind and phase: boundary, detect, sticky, clear
		host.xfer(SEL_OV_THR, 1'b1, 32'hff001000, q);
		check("ov limit", q, 32'h00001000);
		host.xfer(SEL_OI_THR, 1'b1, 32'h00001000, q);
		// Quiet samples, then clear flags left by the sum scenario
		drive('0);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b1, 32'h00160000, q);
		check("flags cleared", q & 32'h00160000, 32'h0);
		check("line clear", {31'h0, event_interrupt_line_1_n}, 32'h1);
		host.xfer(SEL_ENABLE1, 1'b1, 32'h00060000, q);
		check("enable", q, 32'h00060000);
		for (int unsigned k = 0; k < 2; k++) begin
			b = k ? STS1_OI_BIT : STS1_OV_BIT;
			lsb = k ? PH_OI_LSB : PH_OV_LSB;
			for (int p = 0; p < 3; p++) begin
				poke(k, p, 24'hfff000);
				host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, q);
				check("at limit", (q >> b) & 32'h1, 32'h0);
				poke(k, p, 24'hffefff);
				check("ovl line", {31'h0, event_interrupt_line_1_n}, 32'h0);
				poke(k, p, 24'h000000);
				host.service(b, st, ph);
				check("ovl flag", (st >> b) & 32'h1, 32'h1);
				check("ovl phase", (ph >> lsb) & 32'h7, 32'h1 << p);
				host.xfer(SEL_PHASE, 1'b0, '0, q);
				check("ovl cleared", (q >> lsb) & 32'h7, 32'h0);
				check("ovl release", {31'h0, event_interrupt_line_1_n}, 32'h1);
			end
		end
		// Full-scale limit never fires, zero limit always does
		host.xfer(SEL_OV_THR, 1'b1, {8'h00, FULL_SCALE}, q);
		host.xfer(SEL_OI_THR, 1'b1, {8'h00, FULL_SCALE}, q);
		s = '0;
		s.voltage_sample = {FULL_SCALE, 24'h800000, FULL_SCALE};
		s.phase_current_sample = {24'ha58ac0, FULL_SCALE, 24'ha58ac0};
		drive(s);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, q);
		check("full scale", q & 32'h00060000, 32'h0);
		host.xfer(SEL_OV_THR, 1'b1, 32'h00000000, q);
		drive('0);
		check("zero limit line", {31'h0, event_interrupt_line_1_n}, 32'h0);
		host.service(STS1_OV_BIT, st, ph);
		drive('0);
		host.xfer(SEL_EVENT_STATUS_WORD_1, 1'b0, '0, q);
		check("zero limit again", q & 32'h00040000, 32'h00040000);
		host.xfer(SEL_ENABLE1, 1'b1, 32'h00000000, q);
		check("masked line", {31'h0, event_interrupt_line_1_n}, 32'h1);
		final_report();
	end
endmodule : omd_detector_tb_top
